// >>> pressure_out_pkg.sv
package pressure_out_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_HYST   = 8'h04;
    localparam logic [7:0] OFF_SP1_0  = 8'h08;
    localparam logic [7:0] OFF_SP2_0  = 8'h0C;
    localparam logic [7:0] OFF_SP1_1  = 8'h10;
    localparam logic [7:0] OFF_SP2_1  = 8'h14;
    localparam logic [7:0] OFF_LEG_HI = 8'h18;
    localparam logic [7:0] OFF_LEG_LO = 8'h1C;
    localparam logic [7:0] OFF_LEG_SP = 8'h20;
    localparam logic [7:0] OFF_LEG_RP = 8'h24;
    localparam logic [7:0] OFF_ASP    = 8'h28;
    localparam logic [7:0] OFF_AEP    = 8'h2C;
    localparam logic [7:0] OFF_STATUS = 8'h30;
    localparam logic [7:0] OFF_ANALOG = 8'h34;
    localparam logic [7:0] OFF_BAD    = 8'hFF;
    localparam logic [3:0] PARAM_LAST = 4'hB;

    // Control register fields
    localparam int CTL_LEGACY = 0;
    localparam int CTL_INVERT = 1;
    localparam int CTL_FN0    = 2;
    localparam int CTL_FN1    = 4;
    localparam int CTL_ANALOG = 6;
    localparam int CTL_VOLT   = 7;
    localparam int CTL_RANGE  = 8;
    localparam int CTL_AUTO   = 11;
    localparam int CTL_NPN    = 12;

    // Status register fields
    localparam int ST_DRIVE = 0;
    localparam int ST_PROG  = 2;
    localparam int ST_REJ   = 4;

    // Switching functions; in legacy mode window stays window, the rest is hysteresis
    localparam logic [1:0] FN_SINGLE = 2'h0;
    localparam logic [1:0] FN_TWO    = 2'h1;
    localparam logic [1:0] FN_WINDOW = 2'h2;

    // Detection range and derived minimum separations (rounded up)
    localparam logic [15:0] DET_MIN   = 16'h0100;
    localparam logic [15:0] DET_MAX   = 16'hFF00;
    localparam int          SPAN_INT  = 32'(DET_MAX) - 32'(DET_MIN);
    localparam logic [15:0] MEAS_SPAN = 16'(SPAN_INT);
    localparam logic [15:0] MIN_SEP   = 16'((SPAN_INT * 5 + 999) / 1000);
    localparam logic [15:0] MIN_ASPAN = 16'((SPAN_INT * 10 + 99) / 100);

    // Reset values
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [15:0] HYST_RST  = 16'h0100;
    localparam logic [15:0] SP1_RST   = 16'h8000;
    localparam logic [15:0] SP2_RST   = 16'h7000;
    localparam logic [15:0] LHI_RST   = 16'hA000;
    localparam logic [15:0] LLO_RST   = 16'h6000;

    // Output ranges: current in uA, voltage in mV; entry [0] is on the right
    localparam logic [2:0] V_REV_45 = 3'h4;
    localparam logic [3:0][15:0] CUR_LO  = {16'h4E20, 16'h4E20, 16'h0000, 16'h0FA0};
    localparam logic [3:0][15:0] CUR_HI  = {16'h0000, 16'h0FA0, 16'h4E20, 16'h4E20};
    localparam logic [7:0][15:0] VOLT_LO = {16'h1770, 16'h1388, 16'h2710, 16'h1194,
                                            16'h01F4, 16'h03E8, 16'h0000, 16'h0000};
    localparam logic [7:0][15:0] VOLT_HI = {16'h03E8, 16'h0000, 16'h0000, 16'h01F4,
                                            16'h1194, 16'h1770, 16'h1388, 16'h2710};

    typedef enum logic [1:0] {
        PS_RUN  = 2'h0,
        PS_NAV  = 2'h1,
        PS_SHOW = 2'h3
    } prog_t;

endpackage : pressure_out_pkg

// >>> switch_eval.sv
`timescale 1ns/100ps
module switch_eval
    import pressure_out_pkg::*;
(
    // Sample and previous state
    input  wire logic [15:0] pv,
    input  wire logic        prev,
    // Configuration
    input  wire logic        legacy,
    input  wire logic [1:0]  fn,
    input  wire logic [15:0] sp1,
    input  wire logic [15:0] sp2,
    input  wire logic [15:0] hyst,
    input  wire logic [15:0] leg_hi,
    input  wire logic [15:0] leg_lo,
    input  wire logic [15:0] leg_sp,
    input  wire logic [15:0] leg_rp,
    // Result
    output logic             next_active
);
    logic [16:0] up_hyst;
    logic [16:0] lo_hyst;
    logic [16:0] pv_w;
    logic [16:0] lo_single;

    // Widened so that band edges never wrap
    assign pv_w    = {1'b0, pv};
    assign up_hyst = {1'b0, sp1} + {1'b0, hyst};
    assign lo_hyst = {1'b0, sp2} - {1'b0, hyst};
    // A band edge below zero can never be crossed
    assign lo_single = {1'b0, sp1} - {1'b0, hyst};

    always_comb
    begin
        next_active = prev;
        if (legacy)
        begin
            if (fn == FN_WINDOW)
                next_active = (pv >= leg_lo) && (pv <= leg_hi);
            else if (pv > leg_sp)
                next_active = 1'b1;
            else if (pv < leg_rp)
                next_active = 1'b0;
        end
        else
        begin
            case (fn)
                FN_SINGLE:
                begin
                    if (pv > sp1)
                        next_active = 1'b1;
                    else if (!lo_single[16] && (pv_w < lo_single))
                        next_active = 1'b0;
                end
                FN_TWO:
                begin
                    if (pv > sp1)
                        next_active = 1'b1;
                    else if (pv < sp2)
                        next_active = 1'b0;
                end
                FN_WINDOW:
                begin
                    if (prev)
                        next_active = (pv_w <= up_hyst) && (lo_hyst[16] || (pv_w >= lo_hyst));
                    else
                        next_active = (pv >= sp2) && (pv <= sp1);
                end
                default: next_active = 1'b0;
            endcase
        end
    end

endmodule : switch_eval

// >>> pressure_switch_output_logic.sv
// What this block does
// - Normal mode by default, legacy selectable; each output single, two-point or window.
// - One polarity setting inverts every switching output.
// - Single-point: output turns on once rising value exceeds first switch point.
// - Single-point: active output turns off below first switch point minus hysteresis.
// - Hysteresis is accepted only when inside the detection range.
// - Two-point: output turns on when rising value exceeds the switch-on point.
// - Two-point: output stays on above switch-off point, off below it.
// - Window limits must lie inside the detection range.
// - Window rising: off below lower, on inside, off above upper plus hysteresis.
// - Window falling: off above upper, on inside, off below lower minus hysteresis.
// - Legacy window: defined state between limits; limits at least 0.5 % apart.
// - Legacy hysteresis: switch and release points at least 0.5 % apart.
// - Changing the legacy switch point recomputes the release point.
// - Analog start and end points at least ten percent of range apart.
// - Current output scales across the analog start-to-end range.
// - Current ranges 4-20 default, 0-20, 20-4 and 20-0 mA.
// - Voltage output scales likewise; 0-10, 0-5, 1-6, 0.5-4.5 V and reversed.
// - Reversed 4.5-0.5 V range is refused in legacy mode.
// - Second output is switching with chosen or automatic polarity, or analog.
// - When unlocked, the mode pad enters programming mode.
// - Enter shows the selected parameter; mode and set pads navigate.
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
module pressure_switch_output_logic
    import pressure_out_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Process value samples
    input  wire logic [15:0] pv_data,
    input  wire logic        pv_valid,
    // Touchpads
    input  wire logic        unlocked,
    input  wire logic        pad_mode,
    input  wire logic        pad_enter,
    input  wire logic        pad_set,
    output logic             prog_active,
    output logic             show_value,
    output logic [3:0]       param_index,
    output logic [15:0]      param_value,
    // Outputs towards the controller
    input  wire logic        npn_sense,
    output logic [1:0]       sw_out,
    output logic [1:0]       sw_npn,
    output logic             analog_en,
    output logic             analog_voltage,
    output logic [15:0]      analog_value
);

    typedef struct packed {
        logic             addr_ph;
        logic             wr;
        logic [7:0]       addr;
        logic [31:0]      rdata;
        logic [15:0]      ctrl;
        logic [15:0]      hyst;
        logic [1:0][15:0] sp1;
        logic [1:0][15:0] sp2;
        logic [15:0]      leg_hi;
        logic [15:0]      leg_lo;
        logic [15:0]      leg_sp;
        logic [15:0]      leg_rp;
        logic [15:0]      analog_start_point;
        logic [15:0]      analog_end_point;
        logic             rej;
        logic [1:0]       act;
        logic [1:0]       drive;
        logic [15:0]      analog;
        prog_t            pst;
        logic [3:0]       pidx;
        logic [15:0]      pval;
    } st_t;

    localparam st_t ST_RST = '{addr_ph: 1'b0, wr: 1'b0, addr: 8'h00, rdata: 32'h0,
        ctrl: CTRL_RST, hyst: HYST_RST, sp1: {SP1_RST, SP1_RST}, sp2: {SP2_RST, SP2_RST},
        leg_hi: LHI_RST, leg_lo: LLO_RST, leg_sp: SP1_RST, leg_rp: SP2_RST,
        analog_start_point: DET_MIN, analog_end_point: DET_MAX, rej: 1'b0, act: 2'b00, drive: 2'b00,
        analog: 16'h0000, pst: PS_RUN, pidx: 4'h0, pval: 16'h0000};

    st_t         s;
    st_t         nx;
    logic [1:0]  eval_next;
    logic [15:0] wdat;
    logic [15:0] legdiff;
    logic        rej_set;
    logic        rej_clr;
    logic [15:0] frac;
    logic [15:0] rng_lo;
    logic [15:0] rng_hi;
    logic [2:0]  rsel;
    logic signed [17:0] rdiff;
    logic signed [35:0] prod;
    logic signed [17:0] scaled;

    function automatic logic in_det(input logic [15:0] v);
        return (v >= DET_MIN) && (v <= DET_MAX);
    endfunction : in_det

    // Fraction num/den as 16 fractional bits, truncated; only used with num below den
    function automatic logic [15:0] frac_of(input logic [15:0] num, input logic [15:0] den);
        logic [16:0] rem;
        logic [15:0] q;
        rem = {1'b0, num};
        q   = 16'h0000;
        for (int i = 15; i >= 0; i--)
        begin
            rem = {rem[15:0], 1'b0};
            if (rem >= {1'b0, den})
            begin
                rem  = rem - {1'b0, den};
                q[i] = 1'b1;
            end
        end
        return q;
    endfunction : frac_of

    function automatic logic [31:0] reg_word(input st_t v, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0;
        case (a)
            OFF_CTRL:   r[15:0] = v.ctrl;
            OFF_HYST:   r[15:0] = v.hyst;
            OFF_SP1_0:  r[15:0] = v.sp1[0];
            OFF_SP2_0:  r[15:0] = v.sp2[0];
            OFF_SP1_1:  r[15:0] = v.sp1[1];
            OFF_SP2_1:  r[15:0] = v.sp2[1];
            OFF_LEG_HI: r[15:0] = v.leg_hi;
            OFF_LEG_LO: r[15:0] = v.leg_lo;
            OFF_LEG_SP: r[15:0] = v.leg_sp;
            OFF_LEG_RP: r[15:0] = v.leg_rp;
            OFF_ASP:    r[15:0] = v.analog_start_point;
            OFF_AEP:    r[15:0] = v.analog_end_point;
            OFF_STATUS:
            begin
                r[ST_DRIVE +: 2] = v.drive;
                r[ST_PROG +: 2]  = v.pst;
                r[ST_REJ]        = v.rej;
            end
            OFF_ANALOG: r[15:0] = v.analog;
            default:    r = 32'h0;
        endcase
        return r;
    endfunction : reg_word

    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_eval
            switch_eval u_eval (
                .pv          (pv_data),
                .prev        (s.act[ch]),
                .legacy      (s.ctrl[CTL_LEGACY]),
                .fn          (s.ctrl[CTL_FN0 + 2 * ch +: 2]),
                .sp1         (s.sp1[ch]),
                .sp2         (s.sp2[ch]),
                .hyst        (s.hyst),
                .leg_hi      (s.leg_hi),
                .leg_lo      (s.leg_lo),
                .leg_sp      (s.leg_sp),
                .leg_rp      (s.leg_rp),
                .next_active (eval_next[ch])
            );
        end
    endgenerate

    // Analog scaling, clamped at both ends of the start-to-end span
    always_comb
    begin
        if (pv_data <= s.analog_start_point)
            frac = 16'h0000;
        else if (pv_data >= s.analog_end_point)
            frac = 16'hFFFF;
        else
            frac = frac_of(pv_data - s.analog_start_point, s.analog_end_point - s.analog_start_point);
        rsel   = s.ctrl[CTL_RANGE +: 3];
        rng_lo = s.ctrl[CTL_VOLT] ? VOLT_LO[rsel] : CUR_LO[rsel[1:0]];
        rng_hi = s.ctrl[CTL_VOLT] ? VOLT_HI[rsel] : CUR_HI[rsel[1:0]];
        rdiff  = $signed({2'b00, rng_hi}) - $signed({2'b00, rng_lo});
        prod   = 36'(rdiff) * 36'($signed({2'b00, frac}));
        scaled = $signed({2'b00, rng_lo}) + 18'(prod >>> 16);
        // Fraction tops out one code short, so the top clamp is set directly
        if (pv_data >= s.analog_end_point)
            scaled = $signed({2'b00, rng_hi});
    end

    always_comb
    begin
        nx      = s;
        wdat    = hwdata[15:0];
        legdiff = s.leg_sp - s.leg_rp;
        rej_set = 1'b0;
        rej_clr = 1'b0;
        nx.addr_ph = hsel && htrans[1] && hready;
        if (nx.addr_ph)
        begin
            nx.wr   = hwrite;
            nx.addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : OFF_BAD;
        end
        // Illegal values are dropped and flagged instead of stored
        if (s.addr_ph && s.wr)
        begin
            case (s.addr)
                OFF_CTRL:
                    if (wdat[CTL_LEGACY] && wdat[CTL_VOLT] && wdat[CTL_RANGE +: 3] == V_REV_45)
                        rej_set = 1'b1;
                    else
                        nx.ctrl = wdat;
                OFF_HYST:
                    if (wdat <= MEAS_SPAN) nx.hyst = wdat;
                    else rej_set = 1'b1;
                OFF_SP1_0:
                    if (in_det(wdat)) nx.sp1[0] = wdat;
                    else rej_set = 1'b1;
                OFF_SP2_0:
                    if (in_det(wdat)) nx.sp2[0] = wdat;
                    else rej_set = 1'b1;
                OFF_SP1_1:
                    if (in_det(wdat)) nx.sp1[1] = wdat;
                    else rej_set = 1'b1;
                OFF_SP2_1:
                    if (in_det(wdat)) nx.sp2[1] = wdat;
                    else rej_set = 1'b1;
                OFF_LEG_HI:
                    if ({1'b0, wdat} >= {1'b0, s.leg_lo} + {1'b0, MIN_SEP}) nx.leg_hi = wdat;
                    else rej_set = 1'b1;
                OFF_LEG_LO:
                    if ({1'b0, wdat} + {1'b0, MIN_SEP} <= {1'b0, s.leg_hi}) nx.leg_lo = wdat;
                    else rej_set = 1'b1;
                OFF_LEG_SP:
                    // Release point follows, keeping the present hysteresis width
                    if ({1'b0, wdat} >= {1'b0, DET_MIN} + {1'b0, legdiff})
                    begin
                        nx.leg_sp = wdat;
                        nx.leg_rp = wdat - legdiff;
                    end
                    else rej_set = 1'b1;
                OFF_LEG_RP:
                    if ({1'b0, wdat} + {1'b0, MIN_SEP} <= {1'b0, s.leg_sp}) nx.leg_rp = wdat;
                    else rej_set = 1'b1;
                OFF_ASP:
                    if ({1'b0, wdat} + {1'b0, MIN_ASPAN} <= {1'b0, s.analog_end_point}) nx.analog_start_point = wdat;
                    else rej_set = 1'b1;
                OFF_AEP:
                    if ({1'b0, wdat} >= {1'b0, s.analog_start_point} + {1'b0, MIN_ASPAN}) nx.analog_end_point = wdat;
                    else rej_set = 1'b1;
                OFF_STATUS: rej_clr = hwdata[ST_REJ];
                default: rej_clr = 1'b0;
            endcase
        end
        // A refusal in the clearing cycle survives the clear
        nx.rej = (s.rej & ~rej_clr) | rej_set;
        if (pv_valid)
        begin
            nx.act    = eval_next;
            nx.analog = scaled[15:0];
        end
        // Analog second output leaves its switch stage off
        nx.drive    = nx.act ^ {2{nx.ctrl[CTL_INVERT]}};
        nx.drive[1] = nx.drive[1] & ~nx.ctrl[CTL_ANALOG];
        case (s.pst)
            PS_RUN:
                if (unlocked && pad_mode) nx.pst = PS_NAV;
            PS_NAV:
                if (!unlocked) nx.pst = PS_RUN;
                else if (pad_enter) nx.pst = PS_SHOW;
                else if (pad_mode) nx.pidx = (s.pidx == PARAM_LAST) ? 4'h0 : s.pidx + 4'h1;
                else if (pad_set) nx.pidx = (s.pidx == 4'h0) ? PARAM_LAST : s.pidx - 4'h1;
            PS_SHOW:
                if (!unlocked) nx.pst = PS_RUN;
                else if (pad_enter || pad_mode) nx.pst = PS_NAV;
            default: nx.pst = PS_RUN;
        endcase
        // Read data taken from post-write values so back-to-back access sees the write
        if (nx.addr_ph && !hwrite)
            nx.rdata = reg_word(nx, nx.addr);
        nx.pval = 16'(reg_word(nx, {2'b00, nx.pidx, 2'b00}));
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            s <= ST_RST;
        else
            s <= nx;
    end

    // Zero-wait slave, always OKAY
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = s.rdata;
    assign sw_out         = s.drive;
    assign sw_npn[0]      = s.ctrl[CTL_AUTO] ? npn_sense : s.ctrl[CTL_NPN];
    assign sw_npn[1]      = s.ctrl[CTL_AUTO] ? npn_sense : s.ctrl[CTL_NPN + 1];
    assign analog_en      = s.ctrl[CTL_ANALOG];
    assign analog_voltage = s.ctrl[CTL_VOLT];
    assign analog_value   = s.analog;
    assign prog_active    = (s.pst != PS_RUN);
    assign show_value     = (s.pst == PS_SHOW);
    assign param_index    = s.pidx;
    assign param_value    = s.pval;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_HYST_RANGE: assert property (s.hyst <= MEAS_SPAN)
        else $error("hysteresis outside detection range");
    AST_WIN_LIMITS: assert property (in_det(s.sp1[0]) && in_det(s.sp2[0])
        && in_det(s.sp1[1]) && in_det(s.sp2[1]))
        else $error("window limit outside detection range");
    AST_LEG_WINDOW_SEP: assert property (s.leg_hi >= s.leg_lo + MIN_SEP)
        else $error("legacy limits too close");
    AST_LEG_HYST_SEP: assert property (s.leg_sp >= s.leg_rp + MIN_SEP)
        else $error("legacy hysteresis too small");
    AST_RP_FOLLOWS: assert property (s.addr_ph && s.wr && s.addr == OFF_LEG_SP
        && !rej_set |=> (s.leg_sp - s.leg_rp) == $past(legdiff))
        else $error("release point not recomputed");
    AST_ASPAN: assert property ({1'b0, s.analog_end_point} >= {1'b0, s.analog_start_point} + {1'b0, MIN_ASPAN})
        else $error("analog span too small");
    AST_NO_REV45_LEGACY: assert property (!(s.ctrl[CTL_LEGACY] && s.ctrl[CTL_VOLT]
        && s.ctrl[CTL_RANGE +: 3] == V_REV_45))
        else $error("reversed 4.5 V range in legacy mode");
    AST_SINGLE_ON: assert property (pv_valid && !s.ctrl[CTL_LEGACY]
        && s.ctrl[CTL_FN0 +: 2] == FN_SINGLE && pv_data > s.sp1[0] |=> s.act[0])
        else $error("single point did not switch on");
    AST_TWO_OFF: assert property (pv_valid && !s.ctrl[CTL_LEGACY]
        && s.ctrl[CTL_FN0 +: 2] == FN_TWO && pv_data < s.sp2[0] && pv_data <= s.sp1[0]
        |=> !s.act[0])
        else $error("two point did not switch off");
    AST_HOLD: assert property (!pv_valid |=> $stable(s.act))
        else $error("output changed without a sample");
    AST_INVERT: assert property (##1 s.drive[0] == (s.act[0] ^ s.ctrl[CTL_INVERT]))
        else $error("polarity not applied");
    AST_CLAMP_LOW: assert property (pv_valid && pv_data <= s.analog_start_point && !s.ctrl[CTL_VOLT]
        && s.ctrl[CTL_RANGE +: 3] == 3'h0 |=> analog_value == CUR_LO[0])
        else $error("analog not clamped at start point");
    AST_PROG_ENTER: assert property (s.pst == PS_RUN && unlocked && pad_mode
        |=> prog_active ##0 !show_value)
        else $error("programming mode not entered");

    COV_REJECT: cover property (rej_set);
    COV_WINDOW_ON: cover property (s.ctrl[CTL_FN0 +: 2] == FN_WINDOW && $rose(s.act[0]));
    COV_SHOW: cover property (s.pst == PS_NAV ##1 s.pst == PS_SHOW);
    COV_ANALOG_TOP: cover property (pv_valid && pv_data >= s.analog_end_point);

endmodule : pressure_switch_output_logic

// >>> ctrl_input_model.sv
`timescale 1ns/100ps
module ctrl_input_model
(
    // Sensor output pins
    input  wire logic [1:0]  sw_out,
    input  wire logic        analog_en,
    input  wire logic [15:0] analog_value,
    // What the input cards read
    output logic      [1:0]  seen_sw,
    output logic      [15:0] seen_analog
);
    assign seen_sw     = sw_out;
    // Analog card reads zero while the second pin switches
    assign seen_analog = analog_en ? analog_value : 16'h0;
endmodule : ctrl_input_model

// >>> testbench.sv
`timescale 1ns/100ps
module testbench
    import pressure_out_pkg::*;
;
    logic        clk_sys, rst_n, hsel, hwrite, pv_valid, npn_sense, hreadyout, hresp;
    logic        unlocked, pad_mode, pad_enter, pad_set, prog_active, show_value;
    logic        analog_en, analog_voltage;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, sw_out, sw_npn, seen_sw;
    logic [2:0]  hsize;
    logic [3:0]  param_index;
    logic [15:0] pv_data, param_value, analog_value, seen_analog;
    int          miscompares = 0;
    int          n_checks = 0;
    logic [47:0] rows [25] = '{
        {16'h0000,16'h7000,16'h0}, {16'h0000,16'h8001,16'h3}, {16'h0000,16'h7F80,16'h3},
        {16'h0000,16'h7EFF,16'h0}, {16'h0002,16'h7EFF,16'h3}, {16'h0014,16'h8001,16'h3},
        {16'h0014,16'h7100,16'h3}, {16'h0014,16'h6FFF,16'h0}, {16'h0028,16'h7500,16'h3},
        {16'h0028,16'h8080,16'h3}, {16'h0028,16'h8101,16'h0}, {16'h0028,16'h7F00,16'h3},
        {16'h0028,16'h6F80,16'h3}, {16'h0028,16'h6EFF,16'h0}, {16'h0029,16'h9000,16'h3},
        {16'h0029,16'hA001,16'h0}, {16'h0001,16'h8001,16'h3}, {16'h0001,16'h7500,16'h3},
        {16'h0001,16'h6FFF,16'h0}, {16'h0040,16'h0080,16'h0FA0}, {16'h0040,16'h8000,16'h2EE0},
        {16'h0040,16'hFFFF,16'h4E20}, {16'h0240,16'h0080,16'h4E20},
        {16'h00C0,16'h8000,16'h1388}, {16'h07C0,16'h8000,16'h0DAC}};
    pressure_switch_output_logic pressure_switch_output_logic_i (
        .clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .pv_data, .pv_valid, .unlocked, .pad_mode, .pad_enter,
        .pad_set, .prog_active, .show_value, .param_index, .param_value, .npn_sense, .sw_out,
        .sw_npn, .analog_en, .analog_voltage, .analog_value);
    ctrl_input_model ctrl_input_model_i (.sw_out, .analog_en, .analog_value, .seen_sw,
        .seen_analog);
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        miscompares += (seen !== exp);
        if (seen !== exp)
            $display("ERROR %s expected %h seen %h", what, exp, seen);
    endtask : check
    // Holds each phase until hready is seen high at an edge
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        {hsel, htrans, hwrite} <= {1'b1, 2'h2, wr};
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        {hsel, htrans} <= 3'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task try_write(input string what, input logic [7:0] a, input logic [31:0] wd, exp);
        ahb(1'b1, a, wd);
        ahb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : try_write
    // Bits: sample valid, mode, enter, set
    task pulse(input logic [15:0] p, input logic [3:0] v);
        pv_data <= p;
        {pv_valid, pad_mode, pad_enter, pad_set} <= v;
        @(posedge clk_sys);
        {pv_valid, pad_mode, pad_enter, pad_set} <= 4'h0;
        @(posedge clk_sys);
    endtask : pulse
    task report_and_stop(input int extra);
        miscompares += extra;
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial #200000 report_and_stop(1);
    initial
    begin
        {hsel, hwrite, pv_valid, unlocked, pad_mode, pad_enter, pad_set, npn_sense} = '0;
        {haddr, hwdata, htrans, pv_data, rst_n} = '0;
        hsize = 3'h2;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        ahb(1'b0, OFF_CTRL, 32'h0);
        check("ctrl", rd, 32'h0);
        for (int i = 0; i < 25; i++)
        begin
            ahb(1'b1, OFF_CTRL, {16'h0, rows[i][47:32]});
            pulse(rows[i][31:16], 4'h8);
            if (rows[i][32 + CTL_ANALOG])
                check("analog", {16'h0, seen_analog}, {16'h0, rows[i][15:0]});
            else
                check("sw_out", {30'h0, seen_sw}, {16'h0, rows[i][15:0]});
        end
        check("out1", {31'h0, seen_sw[1]}, 32'h0);
        check("volt", {31'h0, analog_voltage}, 32'h1);
        try_write("ctrl", OFF_CTRL, 32'h0481, 32'h07C0);
        try_write("hyst", OFF_HYST, 32'hFFFF, 32'h0100);
        ahb(1'b0, OFF_STATUS, 32'h0);
        check("reject", {31'h0, rd[ST_REJ]}, 32'h1);
        try_write("sp1", OFF_SP1_0, 32'hFF80, 32'h8000);
        try_write("aep", OFF_AEP, 32'h0200, 32'hFF00);
        try_write("lower", OFF_LEG_LO, 32'h9F00, 32'h6000);
        try_write("release", OFF_LEG_RP, 32'h7F00, 32'h7000);
        ahb(1'b1, OFF_LEG_SP, 32'h9000);
        ahb(1'b0, OFF_LEG_RP, 32'h0);
        check("release", rd, 32'h8000);
        npn_sense <= 1'b1;
        try_write("npn", OFF_CTRL, 32'h2000, 32'h2000);
        check("npn", {30'h0, sw_npn}, 32'h2);
        try_write("auto", OFF_CTRL, 32'h0800, 32'h0800);
        check("auto", {30'h0, sw_npn}, 32'h3);
        ahb(1'b1, OFF_STATUS, 32'h10);
        ahb(1'b0, OFF_STATUS, 32'h0);
        check("clear", {31'h0, rd[ST_REJ]}, 32'h0);
        ahb(1'b0, 8'h38, 32'h0);
        check("unmapped", rd, 32'h0);
        pulse(16'h0, 4'h4);
        check("locked", {31'h0, prog_active}, 32'h0);
        unlocked <= 1'b1;
        pulse(16'h0, 4'h4);
        check("prog", {31'h0, prog_active}, 32'h1);
        pulse(16'h0, 4'h2);
        check("show", {31'h0, show_value}, 32'h1);
        pulse(16'h0, 4'h2);
        pulse(16'h0, 4'h1);
        check("index", {28'h0, param_index}, 32'hB);
        check("value", {16'h0, param_value}, 32'hFF00);
        // Mid-run reset must drop programming mode and restore the control word
        rst_n <= 1'b0;
        @(posedge clk_sys);
        check("reset prog", {31'h0, prog_active}, 32'h0);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        ahb(1'b0, OFF_CTRL, 32'h0);
        check("reset ctrl", rd, 32'h0);
        report_and_stop(0);
    end
endmodule : testbench
